// file: rtl/qst_pkg.sv
// package of constants for the questionable status tree
package qst_pkg;
	localparam int NODE_W = 16;
	localparam int NUM_NODES = 13;
	localparam int NUM_CH = 2;

	// physical node index
	localparam logic [3:0] N_OVR = 4'h0;
	localparam logic [3:0] N_LCUR = 4'h1;
	localparam logic [3:0] N_HCUR = 4'h2;
	localparam logic [3:0] N_LMON = 4'h3;
	localparam logic [3:0] N_HMON = 4'h4;
	localparam logic [3:0] N_ENVT = 4'h5;
	localparam logic [3:0] N_PWR = 4'h6;
	localparam logic [3:0] N_MPWR_A = 4'h7;
	localparam logic [3:0] N_MPWR_B = 4'h8;
	localparam logic [3:0] N_INST_A = 4'h9;
	localparam logic [3:0] N_INST_B = 4'ha;
	localparam logic [3:0] N_ISUM = 4'hb;
	localparam logic [3:0] N_QUES = 4'hc;

	// node codes on the command port; module nodes take a channel
	localparam logic [3:0] C_MPWR = 4'h7;
	localparam logic [3:0] C_INST = 4'h8;
	localparam logic [3:0] C_ISUM = 4'h9;
	localparam logic [3:0] C_QUES = 4'ha;

	// channel field of a command
	localparam logic [1:0] CH_NONE = 2'h0;
	localparam logic [1:0] CH_B = 2'h2;

	// register select
	localparam logic [2:0] R_COND = 3'h0;
	localparam logic [2:0] R_EVENT = 3'h1;
	localparam logic [2:0] R_ENABLE = 3'h2;
	localparam logic [2:0] R_PTR = 3'h3;
	localparam logic [2:0] R_NTR = 3'h4;

	// bit positions
	localparam int B_CH_A = 0;
	localparam int B_CH_B = 1;
	localparam int B_PWR_OVR = 0;
	localparam int B_PWR_LCUR = 6;
	localparam int B_PWR_HCUR = 7;
	localparam int B_PWR_LMON = 8;
	localparam int B_PWR_HMON = 9;
	localparam int B_PWR_ENVT = 10;
	localparam int B_INST_PWR = 3;
	localparam int B_ISUM_A = 1;
	localparam int B_ISUM_B = 2;
	localparam int B_QUES_PWR = 3;
	localparam int B_QUES_ISUM = 13;

	// defined bits of each node kind
	localparam logic [15:0] M_LEAF = 16'h0003;
	localparam logic [15:0] M_PWR = 16'h07c1;
	localparam logic [15:0] M_INST = 16'h0008;
	localparam logic [15:0] M_ISUM = 16'h0006;
	localparam logic [15:0] M_QUES = 16'h2008;

	// values after reset
	localparam logic [15:0] RST_ENABLE = 16'h0000;
	localparam logic [15:0] RST_PTR = 16'h7fff;
	localparam logic [15:0] RST_NTR = 16'h0000;
endpackage

// file: rtl/qst_questionable_tree.sv
// questionable status tree: fault leaves, summary nodes, laser shutdown
`timescale 1ns/100ps
// Summary of operation
// R1 - unassigned bits always read zero
// R2 - top node summary drives status byte bit 3
// R3 - top bit 3 summarises power node
// R4 - top bit 13 summarises instrument summary
// R5 - overrange leaf, sensors only, feeds power bit 0
// R6 - low drive leaf feeds power bit 6
// R7 - high drive leaf feeds power bit 7
// R8 - low monitor leaf feeds power bit 8
// R9 - high monitor leaf feeds power bit 9
// R10 - ambient temp leaf feeds power bit 10
// R11 - leaves: channel A bit 0, B bit 1
// R12 - drive fault switches that laser off
// R13 - high monitor fault switches laser off
// R14 - ambient temp fault switches laser off
// R15 - instrument summary: A bit 1, B bit 2
// R16 - module node bit 3 summarises module power
// R17 - module power node mirrors power node layout
// R18 - module node without channel selects A
// R19 - every command accepted whatever is installed
// R20 - nodes sixteen bits, fifteen usable
// R21 - each node has condition, event, enable, filters
// R22 - summary is OR of enabled latched events
module qst_questionable_tree (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [1:0] sensor_present,
	input wire logic [1:0] overrange_in,
	input wire logic [1:0] low_wavelength_drive_fault,
	input wire logic [1:0] high_wavelength_drive_fault,
	input wire logic [1:0] low_wavelength_monitor_fault,
	input wire logic [1:0] high_wavelength_monitor_fault,
	input wire logic [1:0] laser_ambient_temp_fault,
	input wire logic [1:0] laser_restart,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [3:0] cmd_node,
	input wire logic [1:0] cmd_chan,
	input wire logic [2:0] cmd_reg,
	input wire logic [15:0] cmd_wdata,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic [1:0] laser_off,
	output logic stb_questionable
);
	typedef struct packed {
		logic [qst_pkg::NUM_NODES-1:0][15:0] evt;
		logic [qst_pkg::NUM_NODES-1:0][15:0] en;
		logic [qst_pkg::NUM_NODES-1:0][15:0] ptr;
		logic [qst_pkg::NUM_NODES-1:0][15:0] ntr;
		logic [qst_pkg::NUM_NODES-1:0][15:0] prev;
		logic rsp_valid;
		logic [15:0] rsp_data;
		logic [1:0] laser_off;
	} qst_state_s;

	qst_state_s st_q;
	qst_state_s st_d;
	logic [qst_pkg::NUM_NODES-1:0][15:0] cond;
	logic [qst_pkg::NUM_NODES-1:0][15:0] mask;
	logic [qst_pkg::NUM_NODES-1:0] summ;
	logic [3:0] sel;
	logic sel_ok;
	logic cmd_rd;
	logic cmd_wr;
	logic [qst_pkg::NUM_NODES-1:0] node_hit;
	logic [qst_pkg::NUM_NODES-1:0][15:0] evt_nxt;
	logic [qst_pkg::NUM_NODES-1:0][15:0] en_nxt;
	logic [qst_pkg::NUM_NODES-1:0][15:0] ptr_nxt;
	logic [qst_pkg::NUM_NODES-1:0][15:0] ntr_nxt;
	logic [qst_pkg::NUM_NODES-1:0][15:0] node_rd;
	logic [15:0] rd_nxt;
	logic [1:0] laser_trip;
	logic [1:0] laser_off_nxt;

	// defined-bit masks per node
	always_comb begin
		for (int i = 0; i < qst_pkg::NUM_NODES; i++) begin
			mask[i] = qst_pkg::M_LEAF;
		end
		mask[qst_pkg::N_PWR] = qst_pkg::M_PWR;
		mask[qst_pkg::N_MPWR_A] = qst_pkg::M_PWR; // see R17
		mask[qst_pkg::N_MPWR_B] = qst_pkg::M_PWR; // see R17
		mask[qst_pkg::N_INST_A] = qst_pkg::M_INST;
		mask[qst_pkg::N_INST_B] = qst_pkg::M_INST;
		mask[qst_pkg::N_ISUM] = qst_pkg::M_ISUM;
		mask[qst_pkg::N_QUES] = qst_pkg::M_QUES;
	end

	// command qualifiers shared by every node
	assign cmd_rd = cmd_valid && !cmd_write;
	assign cmd_wr = cmd_valid && cmd_write;

	// per-node register logic; summaries come from registered events, so the tree has no loop
	for (genvar g = 0; g < qst_pkg::NUM_NODES; g++) begin : g_node
		logic hit;
		logic rd_clr;
		logic wr_en;
		logic wr_ptr;
		logic wr_ntr;
		logic [15:0] rise;
		logic [15:0] fall;
		logic [15:0] evt_keep;

		assign summ[g] = |(st_q.evt[g] & st_q.en[g]); // see R22

		// command decode for this node
		assign hit = sel_ok && (sel == 4'(g));
		assign rd_clr = cmd_rd && hit && (cmd_reg == qst_pkg::R_EVENT);
		assign wr_en = cmd_wr && hit && (cmd_reg == qst_pkg::R_ENABLE);
		assign wr_ptr = cmd_wr && hit && (cmd_reg == qst_pkg::R_PTR);
		assign wr_ntr = cmd_wr && hit && (cmd_reg == qst_pkg::R_NTR);
		assign node_hit[g] = hit;

		// transition filters
		assign rise = cond[g] & ~st_q.prev[g] & st_q.ptr[g]; // see R21
		assign fall = ~cond[g] & st_q.prev[g] & st_q.ntr[g]; // see R21

		// a clearing read loses to an event of the same cycle, so no transition is dropped
		assign evt_keep = rd_clr ? 16'h0000 : st_q.evt[g];
		assign evt_nxt[g] = (evt_keep | rise | fall) & mask[g]; // see R22 R1

		// undefined bits are dropped on write
		assign en_nxt[g] = wr_en ? (cmd_wdata & mask[g]) : st_q.en[g]; // see R20 R1
		assign ptr_nxt[g] = wr_ptr ? (cmd_wdata & mask[g]) : st_q.ptr[g];
		assign ntr_nxt[g] = wr_ntr ? (cmd_wdata & mask[g]) : st_q.ntr[g];

		// masked again on the way out: the filter reset value sets bits no node defines
		assign node_rd[g] = (cmd_reg == qst_pkg::R_COND) ? (cond[g] & mask[g]) // see R1
			: (cmd_reg == qst_pkg::R_EVENT) ? (st_q.evt[g] & mask[g])
			: (cmd_reg == qst_pkg::R_ENABLE) ? (st_q.en[g] & mask[g])
			: (cmd_reg == qst_pkg::R_PTR) ? (st_q.ptr[g] & mask[g]) // see R1
			: (cmd_reg == qst_pkg::R_NTR) ? (st_q.ntr[g] & mask[g])
			: 16'h0000; // see R1
	end

	// condition inputs of every node
	always_comb begin
		cond = '0;
		cond[qst_pkg::N_OVR][1:0] = overrange_in & sensor_present; // see R5 R11
		cond[qst_pkg::N_LCUR][1:0] = low_wavelength_drive_fault; // see R6 R11
		cond[qst_pkg::N_HCUR][1:0] = high_wavelength_drive_fault; // see R7
		cond[qst_pkg::N_LMON][1:0] = low_wavelength_monitor_fault; // see R8
		cond[qst_pkg::N_HMON][1:0] = high_wavelength_monitor_fault; // see R9
		cond[qst_pkg::N_ENVT][1:0] = laser_ambient_temp_fault; // see R10
		cond[qst_pkg::N_PWR][qst_pkg::B_PWR_OVR] = summ[qst_pkg::N_OVR]; // see R5
		cond[qst_pkg::N_PWR][qst_pkg::B_PWR_LCUR] = summ[qst_pkg::N_LCUR]; // see R6
		cond[qst_pkg::N_PWR][qst_pkg::B_PWR_HCUR] = summ[qst_pkg::N_HCUR]; // see R7
		cond[qst_pkg::N_PWR][qst_pkg::B_PWR_LMON] = summ[qst_pkg::N_LMON]; // see R8
		cond[qst_pkg::N_PWR][qst_pkg::B_PWR_HMON] = summ[qst_pkg::N_HMON]; // see R9
		cond[qst_pkg::N_PWR][qst_pkg::B_PWR_ENVT] = summ[qst_pkg::N_ENVT]; // see R10
		// module power nodes take the raw per-channel faults in the power layout
		for (int c = 0; c < qst_pkg::NUM_CH; c++) begin
			cond[qst_pkg::N_MPWR_A + 4'(c)][qst_pkg::B_PWR_OVR] = overrange_in[c] & sensor_present[c]; // see R17
			cond[qst_pkg::N_MPWR_A + 4'(c)][qst_pkg::B_PWR_LCUR] = low_wavelength_drive_fault[c]; // see R17
			cond[qst_pkg::N_MPWR_A + 4'(c)][qst_pkg::B_PWR_HCUR] = high_wavelength_drive_fault[c]; // see R17
			cond[qst_pkg::N_MPWR_A + 4'(c)][qst_pkg::B_PWR_LMON] = low_wavelength_monitor_fault[c]; // see R17
			cond[qst_pkg::N_MPWR_A + 4'(c)][qst_pkg::B_PWR_HMON] = high_wavelength_monitor_fault[c]; // see R17
			cond[qst_pkg::N_MPWR_A + 4'(c)][qst_pkg::B_PWR_ENVT] = laser_ambient_temp_fault[c]; // see R17
			cond[qst_pkg::N_INST_A + 4'(c)][qst_pkg::B_INST_PWR] = summ[qst_pkg::N_MPWR_A + 4'(c)]; // see R16
		end
		cond[qst_pkg::N_ISUM][qst_pkg::B_ISUM_A] = summ[qst_pkg::N_INST_A]; // see R15
		cond[qst_pkg::N_ISUM][qst_pkg::B_ISUM_B] = summ[qst_pkg::N_INST_B]; // see R15
		cond[qst_pkg::N_QUES][qst_pkg::B_QUES_PWR] = summ[qst_pkg::N_PWR]; // see R3
		cond[qst_pkg::N_QUES][qst_pkg::B_QUES_ISUM] = summ[qst_pkg::N_ISUM]; // see R4
	end

	// map command node code to a physical node
	always_comb begin
		sel_ok = 1'b1;
		sel = cmd_node;
		case (cmd_node)
			qst_pkg::C_MPWR: begin
				sel = (cmd_chan == qst_pkg::CH_B) ? qst_pkg::N_MPWR_B : qst_pkg::N_MPWR_A; // see R18
			end
			qst_pkg::C_INST: begin
				sel = (cmd_chan == qst_pkg::CH_B) ? qst_pkg::N_INST_B : qst_pkg::N_INST_A; // see R18
			end
			qst_pkg::C_ISUM: begin
				sel = qst_pkg::N_ISUM;
			end
			qst_pkg::C_QUES: begin
				sel = qst_pkg::N_QUES;
			end
			default: begin
				// unknown codes are still answered, with zero
				sel_ok = (cmd_node <= qst_pkg::N_PWR); // see R19
			end
		endcase
	end

	// unknown node codes match no node and so answer zero rather than being refused
	always_comb begin
		rd_nxt = 16'h0000;
		for (int i = 0; i < qst_pkg::NUM_NODES; i++) begin
			if (cmd_rd && node_hit[i]) begin
				rd_nxt = node_rd[i]; // see R19
			end
		end
	end

	// the laser latches off until restarted; a fault in the restart cycle wins
	for (genvar c = 0; c < qst_pkg::NUM_CH; c++) begin : g_chan
		logic keep;

		assign laser_trip[c] = low_wavelength_drive_fault[c] // see R12
			| high_wavelength_drive_fault[c] // see R12
			| high_wavelength_monitor_fault[c] // see R13
			| laser_ambient_temp_fault[c]; // see R14
		// a low monitor fault only reports; the laser stays on
		assign keep = st_q.laser_off[c] & ~laser_restart[c];
		assign laser_off_nxt[c] = keep | laser_trip[c];
	end

	// the one process that fills the next state; the loops above feed it
	always_comb begin
		st_d = st_q;
		st_d.evt = evt_nxt;
		st_d.en = en_nxt;
		st_d.ptr = ptr_nxt;
		st_d.ntr = ntr_nxt;
		st_d.prev = cond;
		st_d.rsp_valid = cmd_valid; // see R19
		st_d.rsp_data = rd_nxt;
		st_d.laser_off = laser_off_nxt;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < qst_pkg::NUM_NODES; i++) begin
				st_q.evt[i] <= '0;
				st_q.en[i] <= qst_pkg::RST_ENABLE;
				st_q.ptr[i] <= qst_pkg::RST_PTR;
				st_q.ntr[i] <= qst_pkg::RST_NTR;
				st_q.prev[i] <= '0;
			end
			st_q.rsp_valid <= 1'b0;
			st_q.rsp_data <= '0;
			st_q.laser_off <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rsp_valid = st_q.rsp_valid;
	assign rsp_data = st_q.rsp_data;
	assign laser_off = st_q.laser_off;
	assign stb_questionable = summ[qst_pkg::N_QUES]; // see R2
endmodule // qst_questionable_tree

// file: verif/qst_questionable_tree_asserts.sv
// port assertions for the questionable status tree
`timescale 1ns/100ps
module qst_questionable_tree_chk (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [1:0] low_wavelength_drive_fault,
	input wire logic [1:0] high_wavelength_drive_fault,
	input wire logic [1:0] high_wavelength_monitor_fault,
	input wire logic [1:0] laser_ambient_temp_fault,
	input wire logic [1:0] laser_restart,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [2:0] cmd_reg,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic [1:0] laser_off
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	answer_given_a: assert property (cmd_valid |=> rsp_valid) else $error("no answer");
	no_stray_answer_a: assert property (!cmd_valid |=> !rsp_valid && rsp_data == 16'h0000) else $error("stray answer");
	write_answer_zero_a: assert property (cmd_valid && cmd_write |=> rsp_data == 16'h0000) else $error("write data");
	unmapped_reg_zero_a: assert property (cmd_valid && cmd_reg > 3'h4 |=> rsp_data == 16'h0000) else $error("unmapped");
	low_drive_off_a: assert property (low_wavelength_drive_fault[1] |=> laser_off[1]) else $error("low drive on");
	high_drive_off_a: assert property (|high_wavelength_drive_fault |=> (laser_off & $past(high_wavelength_drive_fault))
		== $past(high_wavelength_drive_fault)) else $error("high drive on");
	high_mon_off_a: assert property (|high_wavelength_monitor_fault |=> (laser_off & $past(high_wavelength_monitor_fault))
		== $past(high_wavelength_monitor_fault)) else $error("monitor on");
	ambient_off_a: assert property (|laser_ambient_temp_fault |=> (laser_off & $past(laser_ambient_temp_fault))
		== $past(laser_ambient_temp_fault)) else $error("ambient on");
	off_holds_a: assert property (laser_off[1] && !laser_restart[1] |=> laser_off[1]) else $error("off lost");
endmodule // qst_questionable_tree_chk
bind qst_questionable_tree qst_questionable_tree_chk qst_questionable_tree_chk_inst (.clk_sys(clk_sys), .reset(reset),
	.low_wavelength_drive_fault(low_wavelength_drive_fault), .high_wavelength_drive_fault(high_wavelength_drive_fault),
	.high_wavelength_monitor_fault(high_wavelength_monitor_fault), .laser_ambient_temp_fault(laser_ambient_temp_fault),
	.laser_restart(laser_restart), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_reg(cmd_reg),
	.rsp_valid(rsp_valid), .rsp_data(rsp_data), .laser_off(laser_off));

// file: verif/tb_qst_questionable_tree.sv
// self-checking bench for the questionable status tree
`timescale 1ns/100ps
module tb_qst_questionable_tree;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [1:0] flt [6] = '{default: 2'h0};
	logic [1:0] sensor_present = 2'h2;
	logic [1:0] laser_restart = 2'h0;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [3:0] cmd_node = 4'h0;
	logic [1:0] cmd_chan = 2'h0;
	logic [2:0] cmd_reg = 3'h0;
	logic [15:0] cmd_wdata = 16'h0000;
	logic rsp_valid;
	logic [15:0] rsp_data;
	logic [1:0] laser_off;
	logic stb_questionable;
	logic [15:0] rd;
	int fails = 0;
	int checks = 0;
	int cycles = 0;
	qst_questionable_tree qst_questionable_tree_inst (.clk_sys(clk_sys), .reset(reset), .sensor_present(sensor_present),
		.overrange_in(flt[0]), .low_wavelength_drive_fault(flt[1]), .high_wavelength_drive_fault(flt[2]),
		.low_wavelength_monitor_fault(flt[3]), .high_wavelength_monitor_fault(flt[4]),
		.laser_ambient_temp_fault(flt[5]), .laser_restart(laser_restart), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_node(cmd_node), .cmd_chan(cmd_chan), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .laser_off(laser_off), .stb_questionable(stb_questionable));
	always #4 clk_sys = ~clk_sys;
	task automatic finish_test();
		if (fails == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// a hang is cut short well past the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input logic w, input logic [3:0] n, input logic [1:0] c, input logic [2:0] r,
		input logic [15:0] d);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_node <= n;
		cmd_chan <= c;
		cmd_reg <= r;
		cmd_wdata <= d;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		#1;
		chk({15'h0000, rsp_valid}, 16'h0001);
		rd = rsp_data;
	endtask
	task automatic rdchk(input logic [3:0] n, input logic [1:0] c, input logic [2:0] r, input logic [15:0] e);
		cmd(1'b0, n, c, r, 16'h0000);
		chk(rd, e);
	endtask
	task automatic t_regs();
		rdchk(4'ha, 2'h0, 3'h2, 16'h0000);
		rdchk(4'h6, 2'h0, 3'h3, qst_pkg::RST_PTR & qst_pkg::M_PWR);
		rdchk(4'h6, 2'h0, 3'h5, 16'h0000);
		rdchk(4'hf, 2'h0, 3'h0, 16'h0000);
		for (int n = 0; n < 11; n++) begin
			cmd(1'b1, n[3:0], 2'h1, 3'h2, 16'hffff);
		end
		cmd(1'b1, 4'h7, 2'h2, 3'h2, 16'hffff);
		cmd(1'b1, 4'h8, 2'h2, 3'h2, 16'hffff);
		rdchk(4'ha, 2'h0, 3'h2, 16'h2008);
		rdchk(4'h6, 2'h0, 3'h2, 16'h07c1);
		rdchk(4'h8, 2'h2, 3'h2, 16'h0008);
		rdchk(4'h9, 2'h0, 3'h2, 16'h0006);
		rdchk(4'h0, 2'h0, 3'h2, 16'h0003);
	endtask
	task automatic t_leaves();
		int pb [6] = '{0, 6, 7, 8, 9, 10};
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			flt[i] <= (i == 0) ? 2'h3 : 2'h2;
			@(posedge clk_sys);
			flt[i] <= 2'h0;
			repeat (6) @(posedge clk_sys);
			#1;
			chk({15'h0000, stb_questionable}, 16'h0001);
			chk({14'h0000, laser_off}, (i == 1 || i == 2 || i > 3) ? 16'h0002 : 16'h0000);
			rdchk(i[3:0], 2'h0, 3'h1, 16'h0002);
			rdchk(4'h6, 2'h0, 3'h1, 16'h0001 << pb[i]);
			rdchk(4'h7, 2'h0, 3'h1, 16'h0000);
			rdchk(4'h7, 2'h2, 3'h1, 16'h0001 << pb[i]);
			rdchk(4'h8, 2'h2, 3'h1, 16'h0008);
			rdchk(4'h9, 2'h0, 3'h1, 16'h0004);
			rdchk(4'ha, 2'h0, 3'h1, 16'h2008);
			chk({15'h0000, stb_questionable}, 16'h0000);
			@(posedge clk_sys);
			laser_restart <= 2'h2;
			@(posedge clk_sys);
			laser_restart <= 2'h0;
			#1;
			chk({14'h0000, laser_off}, 16'h0000);
		end
	endtask
	task automatic t_edges();
		@(posedge clk_sys);
		flt[0] <= 2'h1;
		flt[3] <= 2'h1;
		rdchk(4'h0, 2'h0, 3'h0, 16'h0000);
		chk({14'h0000, laser_off}, 16'h0000);
		@(posedge clk_sys);
		sensor_present <= 2'h3;
		rdchk(4'h0, 2'h0, 3'h0, 16'h0001);
		rdchk(4'h3, 2'h0, 3'h0, 16'h0001);
		cmd(1'b1, 4'h3, 2'h0, 3'h0, 16'h0000);
		cmd(1'b1, 4'h3, 2'h0, 3'h1, 16'h0000);
		rdchk(4'h3, 2'h0, 3'h1, 16'h0001);
		cmd(1'b1, 4'h3, 2'h0, 3'h4, 16'hffff);
		rdchk(4'h3, 2'h0, 3'h4, 16'h0003);
		@(posedge clk_sys);
		flt[0] <= 2'h0;
		flt[3] <= 2'h0;
		rdchk(4'h3, 2'h0, 3'h1, 16'h0001);
		rdchk(4'h3, 2'h0, 3'h1, 16'h0000);
		fork
			cmd(1'b0, 4'h3, 2'h0, 3'h1, 16'h0000);
			begin
				@(posedge clk_sys);
				flt[3] <= 2'h2;
			end
		join
		chk(rd, 16'h0000);
		rdchk(4'h3, 2'h0, 3'h1, 16'h0002);
		@(posedge clk_sys);
		flt[5] <= 2'h1;
		laser_restart <= 2'h1;
		@(posedge clk_sys);
		flt[5] <= 2'h0;
		#1;
		chk({14'h0000, laser_off}, 16'h0001);
		@(posedge clk_sys);
		laser_restart <= 2'h0;
		#1;
		chk({14'h0000, laser_off}, 16'h0000);
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		t_regs();
		t_leaves();
		t_edges();
		finish_test();
	end
endmodule // tb_qst_questionable_tree
